/* src/earth_fault_pkg.sv */
/*
 * constants for the earth fault pick-up stage: register map, field
 * positions, reset values, encodings and the evaluation time base.
 * assumes a 50 MHz system clock and 32-bit register words.
 */
package earth_fault_pkg;
	// ==========================================================
	// clock and time base
	// ==========================================================
	localparam int unsigned CLK_PERIOD_NS = 20; // 50 MHz system clock
	localparam int unsigned TICK_MS = 5; // measurement refresh period
	localparam int unsigned TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned TICK_W = 18; // wide enough for TICK_CYCLES

	// ==========================================================
	// register byte offsets
	// ==========================================================
	localparam logic [7:0] ADDR_CTRL = 8'h00; // static and mode settings
	localparam logic [7:0] ADDR_DELAY = 8'h04; // operate delay, 5 ms units
	localparam logic [7:0] ADDR_STATUS = 8'h08; // condition and readouts
	localparam logic [7:0] ADDR_RATIO = 8'h0C; // measured / threshold
	localparam logic [7:0] ADDR_ANGLE = 8'h10; // residual current angle
	localparam logic [7:0] ADDR_REMAIN = 8'h14; // time left to trip
	localparam logic [7:0] ADDR_EXPECT = 8'h18; // expected operating time
	localparam logic [2:0] ADDR_THR_PAGE = 3'h1; // 0x20..0x3C, one per group

	// ==========================================================
	// control field positions
	// ==========================================================
	localparam int unsigned CTRL_SRC_LSB = 0; // 2 bits, source select
	localparam int unsigned CTRL_MAG_LSB = 2; // 2 bits, magnitude type
	localparam int unsigned CTRL_SIDE_BIT = 4; // measurement module side
	localparam int unsigned CTRL_REMOTE_BIT = 5; // remote threshold allowed
	localparam int unsigned CTRL_MODE_LSB = 6; // 3 bits, node mode
	localparam int unsigned CTRL_FORCE_LSB = 9; // 2 bits, forced status
	localparam int unsigned CTRL_INVERSE_TIME_MODE_BIT = 11; // inverse time delay
	localparam logic [11:0] CTRL_RESET = 12'h000; // all defaults encode as 0

	// ==========================================================
	// encodings
	// ==========================================================
	localparam logic [1:0] SRC_COARSE = 2'h0;
	localparam logic [1:0] SRC_SENSITIVE = 2'h1;
	localparam logic [1:0] SRC_CALC = 2'h2;
	localparam logic [1:0] MAG_RMS = 2'h0;
	localparam logic [1:0] MAG_TRMS = 2'h1;
	localparam logic [1:0] MAG_PP = 2'h2;

	typedef enum logic [2:0] {
		MODE_ON = 3'h0,
		MODE_BLOCKED = 3'h1,
		MODE_TEST = 3'h2,
		MODE_TEST_BLOCKED = 3'h3,
		MODE_OFF = 3'h4
	} node_mode_t;

	// gray along normal -> start -> trip
	typedef enum logic [1:0] {
		COND_NORMAL = 2'h0,
		COND_START = 2'h1,
		COND_TRIP = 2'h3,
		COND_BLOCKED = 2'h2
	} condition_t;

	// ==========================================================
	// values
	// ==========================================================
	localparam int unsigned NUM_GROUPS = 8;
	localparam int unsigned MAG_W = 20; // 0.0001 x nominal per lsb
	localparam logic [19:0] THR_RESET = 20'h0_2EE0; // 1.2000 x nominal
	localparam logic [15:0] DELAY_RESET = 16'h0_000A; // 50 ms
	localparam logic [7:0] PCT_FULL = 8'h64; // 100 %
	localparam logic [7:0] PCT_RESET_RATIO = 8'h61; // 97 %, fixed
	localparam logic [16:0] RATIO_MAX = 17'h1_E848; // 1250.00
	localparam logic [19:0] TIME_MAX = 20'h5_7E40; // 1800.000 s in 5 ms
endpackage

`default_nettype wire

/* src/earth_fault_stage.sv */
/*
 * earth fault pick-up stage: source and magnitude selection, threshold
 * compare with fixed hysteresis, blocking, node mode, forcing, timing
 * and live readouts, with a plain strobe register port.
 * assumes the measurement front end holds its values steady between
 * refreshes and that all inputs are synchronous to ref_clk_in.
 */
`timescale 1ns/100ps
`default_nettype none

module earth_fault_stage #(
	parameter int unsigned TICK_CYCLES_P = earth_fault_pkg::TICK_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	// measurements, indexed by side
	input wire logic [19:0] coarse_rms_in [2],
	input wire logic [19:0] coarse_trms_in [2],
	input wire logic [19:0] coarse_pp_in [2],
	input wire logic [19:0] sensitive_rms_in [2],
	input wire logic [19:0] sensitive_trms_in [2],
	input wire logic [19:0] sensitive_pp_in [2],
	input wire logic [19:0] calculated_residual_current_in [2],
	// angles, 0.01 degree, 0..35999
	input wire logic [15:0] residual_angle_in,
	input wire logic [15:0] pos_seq_voltage_angle_in,
	input wire logic [15:0] pos_seq_current_angle_in,
	input wire logic phase_voltages_present_in,
	// fault classification from the protection logic
	input wire logic [1:0] fault_phase_in,
	input wire logic fault_forward_in,
	// system inputs
	input wire logic block_in,
	input wire logic force_enable_in,
	input wire logic [2:0] active_group_in,
	input wire logic remote_wr_in,
	input wire logic [19:0] remote_threshold_in,
	// stage outputs
	output logic start_out,
	output logic trip_out,
	output logic blocked_out,
	output logic [1:0] condition_out
);
	// ==========================================================
	// functions
	// ==========================================================
	// fault type code: 0 none, 1 A-G-R, 2 B-G-F, 3 C-G-R,
	// 4 A-G-F, 5 B-G-R, 6 C-G-F
	function automatic logic [2:0] fault_code(input logic [1:0] ph, input logic fwd);
		logic [2:0] c;
		c = 3'h0;
		case ({ph, fwd})
			3'b010: c = 3'h1;
			3'b101: c = 3'h2;
			3'b110: c = 3'h3;
			3'b011: c = 3'h4;
			3'b100: c = 3'h5;
			3'b111: c = 3'h6;
			// unused phase codes report none
			default: c = 3'h0;
		endcase
		return c;
	endfunction

	// ==========================================================
	// registers
	// ==========================================================
	logic [11:0] ctrl_q; // control word
	logic [15:0] delay_q; // operate delay, 5 ms units
	logic [19:0] thr_q [earth_fault_pkg::NUM_GROUPS]; // per group threshold
	logic [17:0] tick_cnt_q; // time base divider
	logic tick_q; // one cycle per 5 ms
	logic block_q; // block sampled at cycle start
	logic picked_q; // pick-up held between updates
	earth_fault_pkg::condition_t state_q; // computed condition
	logic [19:0] elapsed_q; // 5 ms ticks since start
	logic [19:0] mag_q; // sampled selected magnitude
	logic [2:0] fault_q; // last fault type
	logic [31:0] rdata_q; // read data, one cycle

	// next values from the tick evaluation
	earth_fault_pkg::condition_t state_d;
	logic picked_d;
	logic [19:0] elapsed_d;

	// ==========================================================
	// field decode
	// ==========================================================
	// control fields, live from the register
	wire logic [1:0] src_sel = ctrl_q[earth_fault_pkg::CTRL_SRC_LSB +: 2];
	wire logic [1:0] mag_sel = ctrl_q[earth_fault_pkg::CTRL_MAG_LSB +: 2];
	wire logic side = ctrl_q[earth_fault_pkg::CTRL_SIDE_BIT];
	wire logic remote_ok = ctrl_q[earth_fault_pkg::CTRL_REMOTE_BIT];
	wire logic [2:0] mode = ctrl_q[earth_fault_pkg::CTRL_MODE_LSB +: 3];
	wire logic [1:0] force_val = ctrl_q[earth_fault_pkg::CTRL_FORCE_LSB +: 2];
	wire logic inverse_time_mode = ctrl_q[earth_fault_pkg::CTRL_INVERSE_TIME_MODE_BIT];

	// one threshold word per setting group
	wire logic thr_page = (reg_addr_in[7:5] == earth_fault_pkg::ADDR_THR_PAGE);
	wire logic [2:0] thr_idx = reg_addr_in[4:2];

	// ==========================================================
	// source and magnitude selection
	// ==========================================================
	// measured inputs honour the magnitude type; calc is fixed
	wire logic [19:0] coarse_mag = (mag_sel == earth_fault_pkg::MAG_TRMS) ?
		coarse_trms_in[side] : (mag_sel == earth_fault_pkg::MAG_PP) ?
		coarse_pp_in[side] : coarse_rms_in[side];
	wire logic [19:0] sens_mag = (mag_sel == earth_fault_pkg::MAG_TRMS) ?
		sensitive_trms_in[side] : (mag_sel == earth_fault_pkg::MAG_PP) ?
		sensitive_pp_in[side] : sensitive_rms_in[side];

	// calc ignores the magnitude type
	wire logic [19:0] selected_mag = (src_sel == earth_fault_pkg::SRC_CALC) ?
		calculated_residual_current_in[side] :
		(src_sel == earth_fault_pkg::SRC_SENSITIVE) ? sens_mag : coarse_mag;

	// ==========================================================
	// compare with hysteresis
	// ==========================================================
	// active group threshold, selected live from active_group_in
	wire logic [19:0] thr = thr_q[active_group_in];

	// both sides in percent: release stays exact
	// and needs no divider
	wire logic [27:0] mag_pct = 28'(mag_q) * 28'(earth_fault_pkg::PCT_FULL);
	wire logic [27:0] rel_pct = 28'(thr) * 28'(earth_fault_pkg::PCT_RESET_RATIO);
	wire logic over = (mag_q > thr);
	wire logic under = (mag_pct < rel_pct);

	// held state picks which compare applies
	wire logic picked_next = picked_q ? !under : over;

	// ==========================================================
	// ratio and expected time
	// ==========================================================
	// divider guarded against a zero threshold
	wire logic [27:0] ratio_raw = (thr == 20'h0_0000) ? 28'h000_0000 : mag_pct / 28'(thr);
	// saturates at the top of the readout range
	wire logic [16:0] ratio = (ratio_raw > 28'(earth_fault_pkg::RATIO_MAX)) ?
		earth_fault_pkg::RATIO_MAX : ratio_raw[16:0];

	// inverse time: delay x 100 / (ratio - 100);
	// at or under the threshold the plain delay
	wire logic [16:0] excess = ratio - 17'(earth_fault_pkg::PCT_FULL);
	wire logic [23:0] inverse_time_mode_raw = (ratio > 17'(earth_fault_pkg::PCT_FULL)) ?
		24'(24'(delay_q) * 24'(earth_fault_pkg::PCT_FULL) / 24'(excess)) : 24'(delay_q);
	wire logic [19:0] expected = !inverse_time_mode ? 20'(delay_q) :
		(inverse_time_mode_raw > 24'(earth_fault_pkg::TIME_MAX)) ?
		earth_fault_pkg::TIME_MAX : inverse_time_mode_raw[19:0];
	// counts down only while starting
	wire logic [19:0] remaining = (state_q == earth_fault_pkg::COND_START &&
		expected > elapsed_q) ? expected - elapsed_q : 20'h0_0000;

	// ==========================================================
	// angle
	// ==========================================================
	// current reference when no voltages
	wire logic [15:0] ref_angle = phase_voltages_present_in ?
		pos_seq_voltage_angle_in : pos_seq_current_angle_in;

	// signed difference, no wrap
	wire logic [16:0] angle = 17'(residual_angle_in) - 17'(ref_angle);

	// ==========================================================
	// mode and forcing
	// ==========================================================
	// node mode decode
	wire logic mode_off = (mode == earth_fault_pkg::MODE_OFF);
	wire logic mode_blk = (mode == earth_fault_pkg::MODE_BLOCKED) ||
		(mode == earth_fault_pkg::MODE_TEST_BLOCKED);
	wire logic mode_test = (mode == earth_fault_pkg::MODE_TEST) ||
		(mode == earth_fault_pkg::MODE_TEST_BLOCKED);

	// forcing replaces the computed condition
	wire logic [1:0] cond = force_enable_in ? force_val : state_q;
	wire logic quiet = mode_test && !force_enable_in; // test keeps start and trip low unless forced

	// ==========================================================
	// next state, evaluated on the tick
	// ==========================================================
	always_comb
	begin
		// hold everything between ticks
		state_d = state_q;
		picked_d = picked_q;
		elapsed_d = elapsed_q;
		// evaluate once per refresh
		if (tick_q)
		begin
			picked_d = picked_next;
			if (mode_off || !picked_next)
			begin
				// released or off: back to normal
				if (mode_off)
					picked_d = 1'b0;
				state_d = earth_fault_pkg::COND_NORMAL;
				elapsed_d = 20'h0_0000;
			end
			else if (block_q || mode_blk)
			begin
				// blocked: start resets, timing stops
				state_d = earth_fault_pkg::COND_BLOCKED;
				elapsed_d = 20'h0_0000;
			end
			// a trip holds until pick-up releases, a block or off mode ends it
			else if (state_q != earth_fault_pkg::COND_TRIP)
			begin
				// unblocked pick-up runs the timer
				elapsed_d = elapsed_q + 20'h0_0001;
				state_d = (elapsed_d >= expected) ? earth_fault_pkg::COND_TRIP :
					earth_fault_pkg::COND_START;
			end
		end
	end

	// ==========================================================
	// time base and block sampling
	// ==========================================================
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			// time base restarts from zero
			tick_cnt_q <= 18'h0_0000;
			tick_q <= 1'b0;
			block_q <= 1'b0;
			mag_q <= 20'h0_0000;
		end
		else
		begin
			// tick pulses in the cycle after the sample
			tick_q <= (tick_cnt_q == 18'(TICK_CYCLES_P - 1));
			// divider wraps once per refresh period
			tick_cnt_q <= (tick_cnt_q == 18'(TICK_CYCLES_P - 1)) ? 18'h0_0000 :
				tick_cnt_q + 18'h0_0001;
			if (tick_cnt_q == 18'(TICK_CYCLES_P - 1))
			begin
				// sample ahead of the evaluation cycle
				block_q <= block_in;
				mag_q <= selected_mag;
			end
		end
	end

	// ==========================================================
	// stage state
	// ==========================================================
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			// normal, released, no fault on record
			state_q <= earth_fault_pkg::COND_NORMAL;
			picked_q <= 1'b0;
			elapsed_q <= 20'h0_0000;
			fault_q <= 3'h0;
		end
		else
		begin
			state_q <= state_d;
			picked_q <= picked_d;
			elapsed_q <= elapsed_d;
			// latched on a fresh start only
			if (state_q == earth_fault_pkg::COND_NORMAL &&
				state_d == earth_fault_pkg::COND_START)
				fault_q <= fault_code(fault_phase_in, fault_forward_in);
		end
	end

	// ==========================================================
	// settings writes
	// ==========================================================
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			// all settings back to defaults
			ctrl_q <= earth_fault_pkg::CTRL_RESET;
			delay_q <= earth_fault_pkg::DELAY_RESET;
			for (int g = 0; g < earth_fault_pkg::NUM_GROUPS; g++)
				thr_q[g] <= earth_fault_pkg::THR_RESET;
		end
		else
		begin
			// static settings and delay
			if (reg_wr_in && reg_addr_in == earth_fault_pkg::ADDR_CTRL)
				ctrl_q <= reg_wdata_in[11:0];
			if (reg_wr_in && reg_addr_in == earth_fault_pkg::ADDR_DELAY)
				delay_q <= reg_wdata_in[15:0];
			// local write wins over a remote one;
			// remote lands in the active group
			if (reg_wr_in && thr_page)
				thr_q[thr_idx] <= reg_wdata_in[19:0];
			else if (remote_wr_in && remote_ok)
				thr_q[active_group_in] <= remote_threshold_in;
		end
	end

	// ==========================================================
	// read path
	// ==========================================================
	// read data stands for one cycle after each strobe cycle; unmapped reads give zero
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
			rdata_q <= 32'h0000_0000;
		// no strobe: the word drops back to zero
		else if (!reg_rd_in)
			rdata_q <= 32'h0000_0000;
		else if (thr_page)
			rdata_q <= 32'(thr_q[thr_idx]);
		else
		begin
			case (reg_addr_in)
				earth_fault_pkg::ADDR_CTRL: rdata_q <= 32'(ctrl_q);
				earth_fault_pkg::ADDR_DELAY: rdata_q <= 32'(delay_q);
				// status: picked, fault, mode, condition
				earth_fault_pkg::ADDR_STATUS:
					rdata_q <= {23'h00_0000, picked_q, fault_q, mode, cond};
				earth_fault_pkg::ADDR_RATIO: rdata_q <= 32'(ratio);
				earth_fault_pkg::ADDR_ANGLE: rdata_q <= {{15{angle[16]}}, angle};
				earth_fault_pkg::ADDR_REMAIN: rdata_q <= 32'(remaining);
				earth_fault_pkg::ADDR_EXPECT: rdata_q <= 32'(expected);
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// outputs
	// ==========================================================
	// read data straight from the register
	assign reg_rdata_out = rdata_q;
	assign condition_out = cond;
	// test mode hides start and trip only
	assign start_out = !quiet && (cond == earth_fault_pkg::COND_START ||
		cond == earth_fault_pkg::COND_TRIP);
	assign trip_out = !quiet && (cond == earth_fault_pkg::COND_TRIP);
	// blocked stays visible in test mode
	assign blocked_out = (cond == earth_fault_pkg::COND_BLOCKED);
endmodule

`default_nettype wire

/* testbench/meas_front_model.sv */
/*
 * model of the residual current front end and the protection logic
 * feeding the earth fault stage: magnitudes, angles, fault class.
 * assumes the bench chooses one live channel and its level.
 */
`timescale 1ns/100ps
`default_nettype none
module meas_front_model #(
	parameter int unsigned PERIOD_P = 10
) (
	input wire logic clk_in,
	input wire logic [3:0] hot_in,
	input wire logic [19:0] level_in,
	output logic [19:0] mag_out [7][2],
	output logic [15:0] ang_out [3],
	output logic [1:0] phase_out,
	output logic fwd_out
);
	// ==========================================================
	// refresh of magnitudes
	// ==========================================================
	int unsigned cnt = 0; // refresh period counter
	// new values land only once a period and hold in between
	always @(posedge clk_in)
	begin
		cnt <= (cnt + 1) % PERIOD_P;
		if (cnt == 0)
			for (int c = 0; c < 7; c++)
				for (int s = 0; s < 2; s++)
					mag_out[c][s] <= (hot_in == 4'(s * 7 + c)) ? level_in : 20'h0_0000;
	end
	// fixed angles: residual, voltage reference, current reference
	assign ang_out[0] = 16'h2328;
	assign ang_out[1] = 16'h0BB8;
	assign ang_out[2] = 16'h03E8;
	// phase b, forward direction
	assign phase_out = 2'h2;
	assign fwd_out = 1'b1;
endmodule
`default_nettype wire

/* testbench/earth_fault_asserts.sv */
/*
 * port checker for the earth fault stage.
 * assumes it is bound to the stage and shares its tick parameter.
 */
`timescale 1ns/100ps
`default_nettype none
module earth_fault_asserts #(
	parameter int unsigned TICK_CYCLES_P = 10
) (
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic block_in,
	input wire logic force_enable_in,
	input wire logic start_out,
	input wire logic trip_out,
	input wire logic blocked_out,
	input wire logic [1:0] condition_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (sys_rst_in);
	// ==========================================================
	// shadow of the control word
	// ==========================================================
	logic [11:0] ctrl_q; // last control word written
	int unsigned since_q; // cycles since that write, saturating
	wire logic [2:0] mode_w = ctrl_q[8:6]; // node mode field
	// track control writes so mode and force checks know the setting
	always_ff @(posedge ref_clk_in)
	begin
		if (sys_rst_in)
		begin
			ctrl_q <= 12'h000;
			since_q <= 0;
		end
		else if (reg_wr_in && reg_addr_in == earth_fault_pkg::ADDR_CTRL)
		begin
			ctrl_q <= reg_wdata_in[11:0];
			since_q <= 0;
		end
		else if (since_q < 1000)
			since_q <= since_q + 1;
	end
	// ==========================================================
	// assertions
	// ==========================================================
	a_read_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000)
		else $error("read data not zero outside the answer cycle");
	a_trip_start: assert property (trip_out |-> start_out && condition_out == earth_fault_pkg::COND_TRIP)
		else $error("trip without start or trip condition");
	a_blocked_alone: assert property (blocked_out |-> !start_out && condition_out == earth_fault_pkg::COND_BLOCKED)
		else $error("blocked output inconsistent");
	a_normal_quiet: assert property (condition_out == earth_fault_pkg::COND_NORMAL |-> !(start_out || trip_out || blocked_out))
		else $error("output active in normal condition");
	a_force_cond: assert property (force_enable_in |-> condition_out == ctrl_q[10:9] && trip_out == (ctrl_q[10:9] == earth_fault_pkg::COND_TRIP))
		else $error("forced status not shown");
	a_block_gate: assert property ($rose(start_out) && !force_enable_in && !$past(force_enable_in) && since_q > 2 |-> !$past(block_in, 2))
		else $error("start raised while block was sampled high");
	a_off_normal: assert property (mode_w == earth_fault_pkg::MODE_OFF && since_q > TICK_CYCLES_P + 3 && !force_enable_in |-> condition_out == earth_fault_pkg::COND_NORMAL && !start_out)
		else $error("off mode not normal");
	a_test_quiet: assert property ((mode_w == earth_fault_pkg::MODE_TEST || mode_w == earth_fault_pkg::MODE_TEST_BLOCKED) && since_q > 1 && !force_enable_in |-> !start_out && !trip_out)
		else $error("test mode drove start or trip");
	// main scenarios reached
	c_start: cover property ($rose(start_out));
	c_trip: cover property ($rose(trip_out));
	c_blocked: cover property ($rose(blocked_out));
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
/*
 * self-checking bench for the earth fault stage over its register port.
 * assumes the front end model and the bound port checker.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	localparam int unsigned TICK = 10; // shortened refresh period
	logic ref_clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic blk = 1'b0;
	logic frc = 1'b0;
	logic [2:0] grp = 3'h0;
	logic rwr = 1'b0;
	logic [19:0] rthr = 20'h0_0000;
	logic pvp = 1'b1;
	logic [3:0] hot = 4'hF; // live channel, none at first
	logic [19:0] lvl = 20'h0_0000;
	logic [31:0] rdata;
	logic start, trip, blocked;
	logic [1:0] cond;
	logic [19:0] mag [7][2];
	logic [15:0] ang [3];
	logic [1:0] ph;
	logic fwd;
	int failures = 0;
	int tests_run = 0;
	int cyc = 0;
	int k, t0;
	logic [31:0] v;
	logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h20, 8'h08, 8'h40}; // reset table
	logic [31:0] re [5] = '{32'h0000_0000, 32'h0000_000A, 32'h0000_2EE0, 32'h0000_0000, 32'h0000_0000};
	logic [19:0] hl [4] = '{20'h0_2EE0, 20'h0_2EE1, 20'h0_2D78, 20'h0_2D77}; // hysteresis steps
	logic [1:0] he [4] = '{2'h0, 2'h1, 2'h1, 2'h0};
	logic [31:0] ms [5] = '{32'h0000_0141, 32'h0000_0146, 32'h0000_0149,
		32'h0000_014E, 32'h0000_0050}; // status per node mode
	always #10 ref_clk_in = ~ref_clk_in;
	earth_fault_stage #(.TICK_CYCLES_P(TICK)) DUT (.ref_clk_in, .sys_rst_in,
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .coarse_rms_in(mag[0]), .coarse_trms_in(mag[1]),
		.coarse_pp_in(mag[2]), .sensitive_rms_in(mag[3]), .sensitive_trms_in(mag[4]),
		.sensitive_pp_in(mag[5]), .calculated_residual_current_in(mag[6]),
		.residual_angle_in(ang[0]), .pos_seq_voltage_angle_in(ang[1]),
		.pos_seq_current_angle_in(ang[2]), .phase_voltages_present_in(pvp),
		.fault_phase_in(ph), .fault_forward_in(fwd), .block_in(blk), .force_enable_in(frc),
		.active_group_in(grp), .remote_wr_in(rwr), .remote_threshold_in(rthr),
		.start_out(start), .trip_out(trip), .blocked_out(blocked), .condition_out(cond));
	meas_front_model #(.PERIOD_P(TICK)) u_front (.clk_in(ref_clk_in), .hot_in(hot),
		.level_in(lvl), .mag_out(mag), .ang_out(ang), .phase_out(ph), .fwd_out(fwd));
	// ==========================================================
	// tasks
	// ==========================================================
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk_in);
	endtask
	// one write cycle, strobe dropped at the taking edge
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk_in);
		wr <= 1'b0;
	endtask
	// one read cycle, data taken in the answer cycle only
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string n);
		@(posedge ref_clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk_in);
		rd <= 1'b0;
		#1 v = rdata;
		chk(n, e, v);
	endtask
	// wait n ticks, compare condition and outputs, end on an edge
	task automatic expect_state(input int n, input logic [1:0] e);
		repeat (n * TICK) @(posedge ref_clk_in);
		#1 chk("condition", 32'(e), 32'(cond));
		chk("outputs", 32'({e[0], e == 2'h3, e == 2'h2}), 32'({start, trip, blocked}));
		@(posedge ref_clk_in);
	endtask
	// hang guard
	always @(posedge ref_clk_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			failures++;
			give_verdict();
		end
	end
	// ==========================================================
	// main sequence
	// ==========================================================
	initial
	begin
		idle(8);
		sys_rst_in <= 1'b0;
		for (int i = 0; i < 5; i++)
			rd_chk(ra[i], re[i], "reset value");
		rd_chk(8'h10, 32'h0000_1770, "angle voltage ref");
		@(posedge ref_clk_in);
		pvp <= 1'b0;
		idle(3 * TICK);
		rd_chk(8'h10, 32'h0000_1F40, "angle current ref");
		$display("test reset and angle done");
		for (int s = 0; s < 2; s++)
			for (int c = 0; c < 7; c++)
			begin
				k = (c < 6 ? (c / 3) + ((c % 3) << 2) : 10) + (s << 4);
				wr_reg(8'h00, 32'(k));
				hot <= 4'(s * 7 + c);
				lvl <= 20'h0_32C8;
				expect_state(3, 2'h1);
				hot <= 4'((1 - s) * 7 + c);
				expect_state(3, 2'h0);
			end
		$display("test source selection done");
		wr_reg(8'h00, 32'h0000_0000);
		hot <= 4'h0;
		for (int i = 0; i < 4; i++)
		begin
			lvl <= hl[i];
			expect_state(3, he[i]);
		end
		rd_chk(8'h08, 32'h0000_0040, "status fault type");
		$display("test hysteresis done");
		wr_reg(8'h04, 32'h0000_0002);
		lvl <= 20'h0_32C8;
		do
		begin
			@(posedge ref_clk_in);
			#1;
		end while (start !== 1'b1);
		t0 = cyc;
		rd_chk(8'h14, 32'h0000_0001, "remaining time");
		do
		begin
			@(posedge ref_clk_in);
			#1;
		end while (trip !== 1'b1);
		chk("ticks to trip", 32'(TICK), 32'(cyc - t0));
		wr_reg(8'h04, 32'h0000_000A);
		lvl <= 20'h0_0000;
		expect_state(3, 2'h0);
		$display("test trip timing done");
		wr_reg(8'h00, 32'h0000_0800);
		lvl <= 20'h0_8CA0;
		idle(3 * TICK);
		rd_chk(8'h0C, 32'h0000_012C, "ratio");
		rd_chk(8'h18, 32'h0000_0005, "expected time");
		@(posedge ref_clk_in);
		lvl <= 20'h0_5DC0;
		idle(3 * TICK);
		rd_chk(8'h0C, 32'h0000_00C8, "ratio");
		rd_chk(8'h18, 32'h0000_000A, "expected time");
		wr_reg(8'h00, 32'h0000_0000);
		lvl <= 20'h0_0000;
		expect_state(3, 2'h0);
		$display("test inverse time done");
		blk <= 1'b1;
		lvl <= 20'h0_32C8;
		expect_state(3, 2'h2);
		blk <= 1'b0;
		expect_state(3, 2'h1);
		blk <= 1'b1;
		expect_state(3, 2'h2);
		blk <= 1'b0;
		lvl <= 20'h0_0000;
		expect_state(3, 2'h0);
		$display("test blocking done");
		frc <= 1'b1;
		for (int f = 0; f < 4; f++)
		begin
			wr_reg(8'h00, 32'(f) << 9);
			expect_state(0, 2'(f));
		end
		frc <= 1'b0;
		expect_state(0, 2'h0);
		$display("test forcing done");
		lvl <= 20'h0_32C8;
		for (int m = 0; m < 5; m++)
		begin
			wr_reg(8'h00, 32'(m) << 6);
			idle(3 * TICK);
			rd_chk(8'h08, ms[m], "status in mode");
			chk("mode readout", 32'(m), 32'(v[4:2]));
			chk("start in mode", 32'(m == 0), 32'(start));
		end
		wr_reg(8'h00, 32'h0000_0000);
		lvl <= 20'h0_0000;
		expect_state(3, 2'h0);
		$display("test node modes done");
		rthr <= 20'h0_36B0;
		rwr <= 1'b1;
		@(posedge ref_clk_in);
		rwr <= 1'b0;
		rd_chk(8'h20, 32'h0000_2EE0, "remote refused");
		wr_reg(8'h00, 32'h0000_0020);
		rwr <= 1'b1;
		@(posedge ref_clk_in);
		rwr <= 1'b0;
		rd_chk(8'h20, 32'h0000_36B0, "remote accepted");
		wr_reg(8'h24, 32'h0000_7530);
		grp <= 3'h1;
		lvl <= 20'h0_4E20;
		expect_state(3, 2'h0);
		grp <= 3'h0;
		expect_state(3, 2'h1);
		$display("test remote and groups done");
		give_verdict();
	end
endmodule
bind earth_fault_stage earth_fault_asserts #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_chk (.ref_clk_in,
	.sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
	.block_in, .force_enable_in, .start_out, .trip_out, .blocked_out, .condition_out);
`default_nettype wire
